// [core/acr_result_select.sv]
// Input-select register, settings latch and result formatting
`timescale 1ns/1ps
module acr_result_select
	import acr_pkg::*;
#(
	parameter int RES_W = ACR_RES_W
)(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        resetn,
	// Register port
	input  wire logic [3:0]  addr,
	input  wire logic [7:0]  wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic      [7:0]  rdata,
	// Converter core
	input  wire logic        conv_start,
	input  wire logic        conv_done,
	input  wire logic [10:0] conv_raw,
	// Applied settings, done flag and interrupt
	output logic      [1:0]  ref_sel,
	output acr_route_s       route,
	output logic             conv_done_flag,
	output logic             irq
);

	// Coding logic is fixed at ten bits
	if (RES_W != ACR_RES_W) begin : g_bad_res_w
		$error("acr_result_select supports only a 10-bit result");
	end

	// ========================================
	// Registers
	logic [7:0]   insel_reg;
	logic         hisel_reg;
	acr_setting_s applied_reg;
	acr_state_e   state_reg;
	logic [9:0]   result_reg;
	logic [1:0]   status_reg;
	logic [1:0]   mask_reg;
	logic         done_pulse_reg;
	logic         ref_bad;

	acr_route_s   route_c;
	acr_route_s   route_reg;
	logic [9:0]   coded;
	logic [7:0]   res_lo;
	logic [7:0]   res_hi;
	logic         insel_wr;
	logic         busy;
	logic [1:0]   ref_field;
	logic [5:0]   chan_code;

	assign insel_wr = wr && addr == ACR_ADDR_INSEL;
	assign busy     = state_reg == ACR_ST_BUSY;
	assign ref_bad  = applied_reg.ref_sel == ACR_REF_RSVD;
	assign ref_field = insel_reg[ACR_REF_HI:ACR_REF_LO];
	assign chan_code = {hisel_reg, insel_reg[ACR_CH_HI:0]};

	// ========================================
	// Software registers
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			insel_reg <= ACR_INSEL_RESET;
			hisel_reg <= 1'b0;
			mask_reg  <= 2'h0;
		end else if (wr) begin
			if (addr == ACR_ADDR_INSEL) begin
				insel_reg <= wdata;
			end else if (addr == ACR_ADDR_HISEL) begin
				hisel_reg <= wdata[0];
			end else if (addr == ACR_ADDR_MASK) begin
				mask_reg <= wdata[1:0];
			end
		end
	end

	// ========================================
	// Conversion state
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_reg <= ACR_ST_IDLE;
		end else begin
			case (state_reg)
				ACR_ST_IDLE: begin
					if (conv_start) begin
						state_reg <= ACR_ST_BUSY;
					end
				end
				ACR_ST_BUSY: begin
					if (conv_done) begin
						state_reg <= ACR_ST_IDLE;
					end
				end
				default: state_reg <= ACR_ST_IDLE;
			endcase
		end
	end

	// Applied settings follow the register only while idle or at the end
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			applied_reg <= '{ACR_REF_EXT, 6'h00};
		end else if (!busy || conv_done) begin
			applied_reg.ref_sel <= acr_ref_e'(ref_field);
			applied_reg.chan    <= chan_code;
		end
	end

	acr_chan_decode u_decode (
		.chan  (applied_reg.chan),
		.route (route_c)
	);

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			route_reg <= '0;
			ref_sel   <= 2'h0;
		end else begin
			route_reg <= route_c;
			ref_sel   <= applied_reg.ref_sel;
		end
	end
	assign route = route_reg;

	// ========================================
	// Result coding
	// Raw input is a signed 11-bit scaled value for differential pairs
	always_comb begin
		if (route_reg.diff) begin
			if ($signed(conv_raw) > $signed({1'b0, ACR_DIFF_MAX})) begin
				coded = ACR_DIFF_MAX;
			end else if ($signed(conv_raw) < -$signed(11'sd512)) begin
				coded = ACR_DIFF_MIN;
			end else begin
				coded = conv_raw[9:0];
			end
		end else if (conv_raw[10]) begin
			coded = 10'h000;
		end else begin
			coded = conv_raw[9:0];
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			result_reg     <= 10'h000;
			done_pulse_reg <= 1'b0;
		end else begin
			done_pulse_reg <= busy && conv_done;
			if (busy && conv_done) begin
				result_reg <= coded;
			end
		end
	end

	acr_justify u_justify (
		.result   (result_reg),
		.left_adj (insel_reg[ACR_LADJ_BIT]),
		.lo       (res_lo),
		.hi       (res_hi)
	);

	// ========================================
	// Sticky status: bit0 done, bit1 reserved reference used
	logic [1:0] evt;
	assign evt = {done_pulse_reg && ref_bad, done_pulse_reg};

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			status_reg <= 2'h0;
		end else begin
			for (int i = 0; i < ACR_NUM_EVT; i++) begin
				if (evt[i]) begin
					status_reg[i] <= 1'b1;
				end else if (wr && addr == ACR_ADDR_STATUS && wdata[i]) begin
					status_reg[i] <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			irq            <= 1'b0;
			conv_done_flag <= 1'b0;
		end else begin
			irq            <= |(status_reg & mask_reg);
			conv_done_flag <= status_reg[0];
		end
	end

	// ========================================
	// Read port
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rdata <= 8'h00;
		end else if (rd) begin
			if (addr == ACR_ADDR_INSEL) begin
				rdata <= insel_reg;
			end else if (addr == ACR_ADDR_HISEL) begin
				rdata <= {7'h00, hisel_reg};
			end else if (addr == ACR_ADDR_RESLO) begin
				rdata <= res_lo;
			end else if (addr == ACR_ADDR_RESHI) begin
				rdata <= res_hi;
			end else if (addr == ACR_ADDR_STATUS) begin
				rdata <= {6'h00, status_reg};
			end else if (addr == ACR_ADDR_MASK) begin
				rdata <= {6'h00, mask_reg};
			end else if (addr == ACR_ADDR_ACTIVE) begin
				rdata <= {applied_reg.ref_sel, busy, applied_reg.chan[4:0]};
			end else begin
				rdata <= 8'h00;
			end
		end else begin
			rdata <= 8'h00;
		end
	end

	// ========================================
	// Checks
	a_settings_hold: assert property (@(posedge clk)
		disable iff (!resetn) busy && !conv_done |=> $stable(applied_reg))
		else $error("settings changed during conversion");

	a_result_capture: assert property (@(posedge clk)
		disable iff (!resetn)
		busy && conv_done |=> result_reg == $past(coded))
		else $error("result not captured at conversion end");

	a_done_flag: assert property (@(posedge clk)
		disable iff (!resetn) busy && conv_done |-> ##3 conv_done_flag)
		else $error("done flag not raised");

	a_status_set: assert property (@(posedge clk)
		disable iff (!resetn) done_pulse_reg |=> status_reg[0])
		else $error("done event lost to a clear");

	a_diff_range: assert property (@(posedge clk)
		disable iff (!resetn)
		route_reg.diff && $signed(conv_raw) > 11'sd511 |-> coded == 10'h1ff)
		else $error("positive clamp wrong");

	a_diff_neg: assert property (@(posedge clk)
		disable iff (!resetn)
		route_reg.diff && $signed(conv_raw) < -11'sd512 |-> coded == 10'h200)
		else $error("negative clamp wrong");

	a_diff_pass: assert property (@(posedge clk)
		disable iff (!resetn)
		route_reg.diff && $signed(conv_raw) >= -11'sd512
		&& $signed(conv_raw) <= 11'sd511 |-> coded == conv_raw[9:0])
		else $error("differential code wrong");

	a_se_floor: assert property (@(posedge clk)
		disable iff (!resetn)
		!route_reg.diff && conv_raw[10] |-> coded == 10'h000)
		else $error("single-ended floor wrong");

	a_se_pass: assert property (@(posedge clk)
		disable iff (!resetn)
		!route_reg.diff && !conv_raw[10] |-> coded == conv_raw[9:0])
		else $error("single-ended code wrong");

	a_justify_now: assert property (@(posedge clk)
		disable iff (!resetn) rd && addr == ACR_ADDR_RESHI && insel_reg[5]
		|=> rdata == $past(result_reg[9:2]))
		else $error("left justify not immediate");

	a_left_low: assert property (@(posedge clk)
		disable iff (!resetn) rd && addr == ACR_ADDR_RESLO && insel_reg[5]
		|=> rdata == {$past(result_reg[1:0]), 6'h00})
		else $error("left justified low byte wrong");

	a_right_low: assert property (@(posedge clk)
		disable iff (!resetn) rd && addr == ACR_ADDR_RESLO && !insel_reg[5]
		|=> rdata == $past(result_reg[7:0]))
		else $error("right justified low byte wrong");

	a_sign_bit: assert property (@(posedge clk)
		disable iff (!resetn) rd && addr == ACR_ADDR_RESHI && !insel_reg[5]
		|=> rdata == {6'h00, $past(result_reg[9:8])})
		else $error("sign bit misplaced");

	a_chan_form: assert property (@(posedge clk)
		disable iff (!resetn)
		!busy |=> applied_reg.chan == $past({hisel_reg, insel_reg[4:0]}))
		else $error("channel code not formed");

	a_ref_follow: assert property (@(posedge clk)
		disable iff (!resetn)
		!busy |=> ##1 ref_sel == $past(insel_reg[7:6], 2))
		else $error("reference not applied");

	a_reserved_flag: assert property (@(posedge clk)
		disable iff (!resetn) done_pulse_reg && ref_bad |=> status_reg[1])
		else $error("reserved reference not flagged");

	a_unused_codes: assert property (@(posedge clk)
		disable iff (!resetn)
		applied_reg.chan inside {6'h02, 6'h03, 6'h08, 6'h0a}
		|=> !route_reg.valid)
		else $error("unavailable code routed");

	a_se_route: assert property (@(posedge clk)
		disable iff (!resetn)
		applied_reg.chan inside {6'h00, 6'h01, [6'h04:6'h07]}
		|=> route_reg.valid && !route_reg.diff
		&& route_reg.pos == $past(applied_reg.chan[2:0]))
		else $error("single-ended route wrong");

	a_gain_10: assert property (@(posedge clk)
		disable iff (!resetn)
		applied_reg.chan == 6'h09 |=> route_reg.diff && route_reg.pos == 3'h1
		&& route_reg.neg == 3'h0 && route_reg.gain == 8'h0a)
		else $error("gain 10 pair wrong");

	a_gain_200: assert property (@(posedge clk)
		disable iff (!resetn)
		applied_reg.chan == 6'h0b |=> route_reg.diff && route_reg.pos == 3'h1
		&& route_reg.neg == 3'h0 && route_reg.gain == 8'hc8)
		else $error("gain 200 not applied");

	a_gain_1: assert property (@(posedge clk)
		disable iff (!resetn)
		applied_reg.chan == 6'h10 |=> route_reg.diff && route_reg.pos == 3'h0
		&& route_reg.neg == 3'h1 && route_reg.gain == 8'h01)
		else $error("gain 1 pair wrong");

	a_irq_level: assert property (@(posedge clk)
		disable iff (!resetn) (|(status_reg & mask_reg)) |=> irq)
		else $error("interrupt not raised");

	a_rdata_idle: assert property (@(posedge clk)
		disable iff (!resetn) !rd |=> rdata == 8'h00)
		else $error("read data not cleared");

	c_conv_done: cover property (@(posedge clk) disable iff (!resetn)
		busy && conv_done);
	c_diff_done: cover property (@(posedge clk) disable iff (!resetn)
		busy && conv_done && route_reg.diff);
	c_write_busy: cover property (@(posedge clk) disable iff (!resetn)
		busy && insel_wr);
	c_irq: cover property (@(posedge clk) disable iff (!resetn) irq);

endmodule : acr_result_select

// [pkg/acr_pkg.sv]
// Package for the converter result and input-select block
package acr_pkg;

	// ========================================
	// Register map
	localparam logic [3:0] ACR_ADDR_INSEL  = 4'h0;
	localparam logic [3:0] ACR_ADDR_HISEL  = 4'h1;
	localparam logic [3:0] ACR_ADDR_RESLO  = 4'h2;
	localparam logic [3:0] ACR_ADDR_RESHI  = 4'h3;
	localparam logic [3:0] ACR_ADDR_STATUS = 4'h4;
	localparam logic [3:0] ACR_ADDR_MASK   = 4'h5;
	localparam logic [3:0] ACR_ADDR_ACTIVE = 4'h6;

	// ========================================
	// Field positions and reset values
	localparam int         ACR_REF_HI      = 7;
	localparam int         ACR_REF_LO      = 6;
	localparam int         ACR_LADJ_BIT    = 5;
	localparam int         ACR_CH_HI       = 4;
	localparam logic [7:0] ACR_INSEL_RESET = 8'h00;
	localparam int         ACR_RES_W       = 10;
	localparam int         ACR_NUM_EVT     = 2;

	// ========================================
	// Codes
	localparam logic [9:0] ACR_SE_MAX   = 10'h3ff;
	localparam logic [9:0] ACR_DIFF_MAX = 10'h1ff;
	localparam logic [9:0] ACR_DIFF_MIN = 10'h200;

	typedef enum logic [1:0] {
		ACR_REF_EXT,
		ACR_REF_SUPPLY,
		ACR_REF_RSVD,
		ACR_REF_INT256
	} acr_ref_e;

	typedef enum {
		ACR_ST_IDLE,
		ACR_ST_BUSY
	} acr_state_e;

	typedef struct packed {
		logic       valid;
		logic       diff;
		logic [2:0] pos;
		logic [2:0] neg;
		logic [7:0] gain;
	} acr_route_s;

	typedef struct packed {
		acr_ref_e   ref_sel;
		logic [5:0] chan;
	} acr_setting_s;

endpackage : acr_pkg

// [core/acr_chan_decode.sv]
// Channel code decoder: inputs and gain
`timescale 1ns/1ps
module acr_chan_decode
	import acr_pkg::*;
(
	// Code in
	input  wire logic [5:0] chan,
	// Route out
	output acr_route_s      route
);

	always_comb begin
		route = '0;
		if (chan == 6'h00 || chan == 6'h01) begin
			route.valid = 1'b1;
			route.pos   = chan[2:0];
		end else if (chan >= 6'h04 && chan <= 6'h07) begin
			route.valid = 1'b1;
			route.pos   = chan[2:0];
		end else if (chan == 6'h09) begin
			route = '{1'b1, 1'b1, 3'h1, 3'h0, 8'h0a};
		end else if (chan == 6'h0b) begin
			route = '{1'b1, 1'b1, 3'h1, 3'h0, 8'hc8};
		end else if (chan == 6'h10) begin
			route = '{1'b1, 1'b1, 3'h0, 3'h1, 8'h01};
		end
	end

endmodule : acr_chan_decode

// [core/acr_justify.sv]
// Result justification onto two byte registers
`timescale 1ns/1ps
module acr_justify
	import acr_pkg::*;
(
	// Result in
	input  wire logic [9:0] result,
	input  wire logic       left_adj,
	// Bytes out
	output logic      [7:0] lo,
	output logic      [7:0] hi
);

	always_comb begin
		if (left_adj) begin
			hi = result[9:2];
			lo = {result[1:0], 6'h00};
		end else begin
			lo = result[7:0];
			hi = {6'h00, result[9:8]};
		end
	end

endmodule : acr_justify

// [bench/analog_conv_result_select_tb_top.sv]
// Testbench for the converter result and input-select block
`timescale 1ns/1ps
`define CHK(n, e, g) begin \
	num_checks++; \
	if ((g) !== (e)) begin \
		fails++; \
		$display("wrong value %s exp %h got %h", n, e, g); \
	end \
end
module analog_conv_result_select_tb_top
	import acr_pkg::*;
;
	logic        clk = 1'b0;
	logic        resetn = 1'b0;
	logic [3:0]  addr;
	logic [7:0]  wdata;
	logic [7:0]  rdata;
	logic        wr;
	logic        rd;
	logic        conv_start;
	logic        conv_done;
	logic [10:0] conv_raw;
	logic [1:0]  ref_sel;
	acr_route_s  route;
	logic        conv_done_flag;
	logic        irq;
	int          fails;
	int          num_checks;
	logic [10:0] raws [8] = '{11'h670, 11'h7ff, 11'h3ff, 11'h400,
		11'h000, 11'h3ff, 11'h7ff, 11'h123};
	logic [5:0]  codes [8] = '{6'h09, 6'h10, 6'h0b, 6'h09,
		6'h09, 6'h00, 6'h04, 6'h05};
	logic [9:0]  exps [8] = '{10'h270, 10'h3ff, 10'h1ff, 10'h200,
		10'h000, 10'h3ff, 10'h000, 10'h123};

	always #5 clk = ~clk;

	acr_result_select dut (
		.clk            (clk),
		.resetn         (resetn),
		.addr           (addr),
		.wdata          (wdata),
		.wr             (wr),
		.rd             (rd),
		.rdata          (rdata),
		.conv_start     (conv_start),
		.conv_done      (conv_done),
		.conv_raw       (conv_raw),
		.ref_sel        (ref_sel),
		.route          (route),
		.conv_done_flag (conv_done_flag),
		.irq            (irq)
	);

	// ========================================
	// Bus and converter tasks
	task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg

	task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask : rd_reg

	task automatic start_conv;
		@(posedge clk);
		conv_start <= 1'b1;
		@(posedge clk);
		conv_start <= 1'b0;
	endtask : start_conv

	task automatic end_conv(input logic [10:0] raw);
		@(posedge clk);
		conv_raw <= raw;
		conv_done <= 1'b1;
		@(posedge clk);
		conv_done <= 1'b0;
		repeat (5) @(posedge clk);
	endtask : end_conv

	task automatic conclude;
		if (fails == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : conclude

	// ========================================
	// Watchdog
	initial begin
		repeat (20000) @(posedge clk);
		fails++;
		conclude();
	end

	// ========================================
	// Tests
	initial begin
		logic [7:0] d;
		logic [5:0] c;
		logic [9:0] r;
		logic [1:0] rf;
		logic       v;
		logic       df;
		logic [2:0] p;
		logic [7:0] g;
		logic [7:0] lo;
		logic [7:0] hi;
		addr = 4'h0;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
		conv_start = 1'b0;
		conv_done = 1'b0;
		conv_raw = 11'h000;
		repeat (12) @(posedge clk);
		resetn <= 1'b1;
		rd_reg(ACR_ADDR_INSEL, d);
		`CHK("insel reset", 8'h00, d)
		wr_reg(4'h7, 8'hff);
		rd_reg(4'h7, d);
		`CHK("unmapped read", 8'h00, d)
		rd_reg(ACR_ADDR_INSEL, d);
		`CHK("insel untouched", 8'h00, d)
		// Channel decode table
		for (int i = 0; i < 14; i++) begin
			c = (i == 12) ? 6'h10 : (i == 13) ? 6'h29 : i[5:0];
			wr_reg(ACR_ADDR_HISEL, {7'h00, c[5]});
			wr_reg(ACR_ADDR_INSEL, {3'b000, c[4:0]});
			repeat (4) @(posedge clk);
			v = !(c inside {6'h02, 6'h03, 6'h08, 6'h0a, 6'h29});
			df = c inside {6'h09, 6'h0b, 6'h10};
			p = df ? {2'b00, c != 6'h10} : c[2:0];
			g = (c == 6'h09) ? 8'h0a : (c == 6'h0b) ? 8'hc8 : 8'h01;
			`CHK("route valid", v, route.valid)
			if (v) `CHK("route diff", df, route.diff)
			if (v) `CHK("route pos", p, route.pos)
			if (df) `CHK("route neg", {2'b00, c == 6'h10}, route.neg)
			if (df) `CHK("route gain", g, route.gain)
		end
		rd_reg(ACR_ADDR_HISEL, d);
		`CHK("high select", 8'h01, d)
		// Conversions, formats and justification
		for (int i = 0; i < 8; i++) begin
			rf = i[1:0];
			c = codes[i];
			r = exps[i];
			wr_reg(ACR_ADDR_HISEL, {7'h00, c[5]});
			wr_reg(ACR_ADDR_INSEL, {rf, 1'b0, c[4:0]});
			repeat (4) @(posedge clk);
			`CHK("ref_sel", rf, ref_sel)
			start_conv();
			end_conv(raws[i]);
			`CHK("done flag", 1'b1, conv_done_flag)
			`CHK("irq masked", 1'b0, irq)
			rd_reg(ACR_ADDR_STATUS, d);
			`CHK("status", {6'h00, rf == 2'b10, 1'b1}, d)
			wr_reg(ACR_ADDR_STATUS, 8'h03);
			for (int j = 0; j < 2; j++) begin
				wr_reg(ACR_ADDR_INSEL, {rf, j[0], c[4:0]});
				lo = j ? {r[1:0], 6'h00} : r[7:0];
				hi = j ? r[9:2] : {6'h00, r[9:8]};
				rd_reg(ACR_ADDR_RESLO, d);
				`CHK("result low", lo, d)
				rd_reg(ACR_ADDR_RESHI, d);
				`CHK("result high", hi, d)
			end
		end
		// Settings held through a running conversion
		wr_reg(ACR_ADDR_HISEL, 8'h00);
		wr_reg(ACR_ADDR_INSEL, 8'h40);
		repeat (4) @(posedge clk);
		start_conv();
		wr_reg(ACR_ADDR_INSEL, 8'he9);
		repeat (4) @(posedge clk);
		`CHK("ref held", 2'b01, ref_sel)
		`CHK("route held", 1'b0, route.diff)
		rd_reg(ACR_ADDR_ACTIVE, d);
		`CHK("active", 8'h60, d)
		rd_reg(ACR_ADDR_RESHI, d);
		`CHK("justify while busy", 8'h48, d)
		wr_reg(ACR_ADDR_MASK, 8'h01);
		rd_reg(ACR_ADDR_MASK, d);
		`CHK("mask", 8'h01, d)
		end_conv(11'h7ff);
		`CHK("ref applied", 2'b11, ref_sel)
		`CHK("route applied", 1'b1, route.diff)
		rd_reg(ACR_ADDR_RESLO, d);
		`CHK("old setting result", 8'h00, d)
		`CHK("irq raised", 1'b1, irq)
		wr_reg(ACR_ADDR_STATUS, 8'h01);
		repeat (4) @(posedge clk);
		`CHK("irq cleared", 1'b0, irq)
		`CHK("flag cleared", 1'b0, conv_done_flag)
		conclude();
	end
endmodule : analog_conv_result_select_tb_top
